// ---- src/asf_cfg.svh ----
// offsets, field positions and reset values of the serial status block
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH

// ====================================================================
// register byte offsets
`define ASF_OFS_STATUS 4'h0
`define ASF_OFS_DATA 4'h4
`define ASF_OFS_CTRL 4'h8

// ====================================================================
// status field positions
`define ASF_TX_EMPTY 7
`define ASF_TX_DONE 6
`define ASF_RX_READY 5
`define ASF_IDLE 4
`define ASF_OVERRUN 3
`define ASF_NOISE 2
`define ASF_FRAMING 1
`define ASF_PARITY 0

// ====================================================================
// control field positions
`define ASF_C_TX_EMPTY_IE 7
`define ASF_C_TX_DONE_IE 6
`define ASF_C_RECEIVE_IE 5
`define ASF_C_IDLE_IE 4
`define ASF_C_WORD9 3
`define ASF_C_PARITY_EN 2
`define ASF_C_PARITY_SEL 1
`define ASF_C_PARITY_IE 0

// ====================================================================
// reset values and clear groups
`define ASF_STATUS_RST 8'hc0
`define ASF_CTRL_RST 8'h00
`define ASF_RX_CLR_MASK 8'h3f
`define ASF_TX_CLR_MASK 8'hc1

`endif

// ---- src/asf_pkg.sv ----
// types shared by the serial status block
package asf_pkg;
  typedef enum logic [0:0] {
    ASF_BUS_IDLE = 1'b0,
    ASF_BUS_ACK = 1'b1
  } asf_bus_st_t;
endpackage

// ---- src/asf_bit_voter.sv ----
// majority vote and noise detect over the mid-bit samples
`timescale 1ns/100ps
`default_nettype none
module asf_bit_voter
  import asf_pkg::*;
(
  input wire logic core_clk, // 125 MHz clock
  input wire logic rstn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic frame_start, // start of a received frame
  input wire logic bit_stb, // samples of one bit are ready
  input wire logic [2:0] mid_samples, // samples 8, 9 and 10
  output logic bit_val_q, // voted bit value
  output logic frame_noise_q // noise seen in this frame
);
  logic maj;
  logic mism;

  assign maj = (mid_samples[0] & mid_samples[1])
             | (mid_samples[0] & mid_samples[2])
             | (mid_samples[1] & mid_samples[2]);
  assign mism = ~(&mid_samples) & (|mid_samples);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      bit_val_q <= 1'b0;
    else if (ce && bit_stb)
      bit_val_q <= maj;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      frame_noise_q <= 1'b0;
    else if (ce && frame_start)
      frame_noise_q <= 1'b0;
    else if (ce && bit_stb && mism)
      frame_noise_q <= 1'b1;
  end

  a_noise_mismatch: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && bit_stb && !frame_start && (mid_samples == 3'b010)
    |=> frame_noise_q && !bit_val_q)
    else $error("mismatched samples did not flag noise");
endmodule
`default_nettype wire

// ---- src/asf_status_core.sv ----
// status flags, clear sequences and register port of the serial block
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "asf_cfg.svh"
module asf_status_core
  import asf_pkg::*;
(
  input wire logic core_clk, // 125 MHz clock
  input wire logic rstn, // sync reset, active low
  input wire logic ce, // clock enable, freezes all state
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic tx_load, // holding moved into tx shifter
  input wire logic tx_frame_done, // tx frame finished
  input wire logic tx_frame_is_data, // that frame carried data
  output logic [7:0] tx_hold_q, // tx holding contents
  output logic tx_hold_full, // tx holding awaits the shifter
  input wire logic rx_frame_start, // rx frame begins
  input wire logic rx_bit_stb, // mid-bit samples ready
  input wire logic [2:0] rx_mid_samples, // samples 8, 9, 10
  output logic rx_bit_val, // voted bit value
  input wire logic rx_word_stb, // rx shifter word complete
  input wire logic [8:0] rx_word, // received word incl parity
  input wire logic rx_frame_fault, // desync, noise or break
  input wire logic idle_detect, // idle line seen
  output logic [7:0] ctrl_q, // control register
  output logic irq // shared interrupt request
);
  // ==================================================================
  // bus slave
  asf_bus_st_t bus_q;
  logic req;
  logic acc;
  logic sel_stat;
  logic sel_data;
  logic sel_ctrl;
  logic stat_acc;
  logic data_rd;
  logic data_wr;
  logic ctrl_wr;
  logic [31:0] rdata_q;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] rx_hold_q;

  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ((bus_q != ASF_BUS_ACK) | ~ce);
  assign acc = ce & req & (bus_q == ASF_BUS_ACK);
  assign sel_stat = (avs_address == `ASF_OFS_STATUS);
  assign sel_data = (avs_address == `ASF_OFS_DATA);
  assign sel_ctrl = (avs_address == `ASF_OFS_CTRL);
  assign stat_acc = acc & sel_stat;
  assign data_rd = acc & avs_read & sel_data;
  assign data_wr = acc & avs_write & sel_data & avs_byteenable[0];
  assign ctrl_wr = acc & avs_write & sel_ctrl & avs_byteenable[0];
  assign avs_readdata = rdata_q;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      bus_q <= ASF_BUS_IDLE;
    else if (ce)
    begin
      case (bus_q)
        ASF_BUS_IDLE: bus_q <= req ? ASF_BUS_ACK : ASF_BUS_IDLE;
        ASF_BUS_ACK: bus_q <= ASF_BUS_IDLE;
        default: bus_q <= ASF_BUS_IDLE;
      endcase
    end
  end

  // read data latched one cycle ahead of the answer
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rdata_q <= 32'h0000_0000;
    else if (ce && avs_read && bus_q == ASF_BUS_IDLE)
    begin
      if (sel_stat)
        rdata_q <= {24'h00_0000, stat_q};
      else if (sel_data)
        rdata_q <= {24'h00_0000, rx_hold_q};
      else if (sel_ctrl)
        rdata_q <= {24'h00_0000, ctrl_q};
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      ctrl_q <= `ASF_CTRL_RST;
    else if (ctrl_wr)
      ctrl_q <= avs_writedata[7:0];
  end

  // ==================================================================
  // clear sequence: arm on status access, act on next data access
  logic arm_q;
  logic [7:0] snap_q;
  logic [7:0] clr;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      arm_q <= 1'b0;
      snap_q <= 8'h00;
    end
    else if (stat_acc)
    begin
      arm_q <= 1'b1;
      snap_q <= stat_q;
    end
    else if (data_rd || (acc && sel_data && avs_write))
      arm_q <= 1'b0;
  end

  always_comb
  begin
    clr = 8'h00;
    if (arm_q && data_rd)
      clr = snap_q & `ASF_RX_CLR_MASK;
    if (arm_q && data_wr)
      clr = clr | (snap_q & `ASF_TX_CLR_MASK);
  end

  // ==================================================================
  // transmit side
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      tx_hold_q <= 8'h00;
    else if (data_wr)
      tx_hold_q <= avs_writedata[7:0];
  end

  assign tx_hold_full = ~stat_q[`ASF_TX_EMPTY];

  // ==================================================================
  // receive side
  logic frame_noise;
  logic word_ok;
  logic word_ovr;
  logic par_fail;
  logic idle_ok_q;
  logic [8:0] par_bits;

  asf_bit_voter u_voter (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .frame_start(rx_frame_start),
    .bit_stb(rx_bit_stb),
    .mid_samples(rx_mid_samples),
    .bit_val_q(rx_bit_val),
    .frame_noise_q(frame_noise)
  );

  assign word_ok = rx_word_stb & ~stat_q[`ASF_RX_READY];
  assign word_ovr = rx_word_stb & stat_q[`ASF_RX_READY];
  // 8 bits with parity for short words, 9 for long words
  assign par_bits = ctrl_q[`ASF_C_WORD9] ? rx_word : {1'b0, rx_word[7:0]};
  assign par_fail = ctrl_q[`ASF_C_PARITY_EN]
                  & ((^par_bits) ^ ctrl_q[`ASF_C_PARITY_SEL]);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rx_hold_q <= 8'h00;
    else if (ce && word_ok)
      rx_hold_q <= rx_word[7:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      idle_ok_q <= 1'b1;
    else if (ce && word_ok)
      idle_ok_q <= 1'b1;
    else if (ce && idle_detect && idle_ok_q)
      idle_ok_q <= 1'b0;
  end

  // ==================================================================
  // status flags: set wins over clear
  always_comb
  begin
    stat_d = stat_q & ~clr;
    if (tx_load)
      stat_d[`ASF_TX_EMPTY] = 1'b1;
    if (tx_frame_done && tx_frame_is_data)
      stat_d[`ASF_TX_DONE] = 1'b1;
    if (word_ok)
    begin
      stat_d[`ASF_RX_READY] = 1'b1;
      if (frame_noise)
        stat_d[`ASF_NOISE] = 1'b1;
      if (rx_frame_fault)
        stat_d[`ASF_FRAMING] = 1'b1;
      if (par_fail)
        stat_d[`ASF_PARITY] = 1'b1;
    end
    if (word_ovr)
      stat_d[`ASF_OVERRUN] = 1'b1;
    if (idle_detect && idle_ok_q)
      stat_d[`ASF_IDLE] = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      stat_q <= `ASF_STATUS_RST;
    else if (ce)
      stat_q <= stat_d;
  end

  // ==================================================================
  // shared interrupt
  assign irq = (stat_q[`ASF_TX_EMPTY] & ctrl_q[`ASF_C_TX_EMPTY_IE])
    | (stat_q[`ASF_TX_DONE] & ctrl_q[`ASF_C_TX_DONE_IE])
    | ((stat_q[`ASF_RX_READY] | stat_q[`ASF_OVERRUN])
       & ctrl_q[`ASF_C_RECEIVE_IE])
    | (stat_q[`ASF_IDLE] & ctrl_q[`ASF_C_IDLE_IE])
    | (stat_q[`ASF_PARITY] & ctrl_q[`ASF_C_PARITY_IE]);

  // ==================================================================
  // checks
  sequence s_stat_rd;
    ce && stat_acc && avs_read;
  endsequence

  sequence s_data_rd;
    ce && data_rd && arm_q && !rx_word_stb && !idle_detect;
  endsequence

  sequence s_stat_acc;
    ce && stat_acc;
  endsequence

  sequence s_tx_wr;
    ce && data_wr && arm_q && snap_q[`ASF_TX_DONE] && !tx_frame_done;
  endsequence

  a_status_reset: assert property (@(posedge core_clk)
    !rstn |=> stat_q == 8'hc0)
    else $error("status reset value wrong");

  a_tx_empty_set: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && tx_load |=> stat_q[`ASF_TX_EMPTY] && tx_hold_full == 1'b0)
    else $error("tx-empty not set on load");

  a_tx_empty_irq: assert property (@(posedge core_clk) disable iff (!rstn)
    stat_q[`ASF_TX_EMPTY] && ctrl_q[`ASF_C_TX_EMPTY_IE] |-> irq)
    else $error("tx-empty interrupt missing");

  a_tx_clear_seq: assert property (@(posedge core_clk) disable iff (!rstn)
    s_stat_acc ##[1:20] s_tx_wr |=> !stat_q[`ASF_TX_DONE])
    else $error("tx-done not cleared by sequence");

  a_tx_done_nodata: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && tx_frame_done && !tx_frame_is_data && !stat_q[`ASF_TX_DONE]
    |=> !stat_q[`ASF_TX_DONE])
    else $error("tx-done set by non-data frame");

  a_rx_clear_seq: assert property (@(posedge core_clk) disable iff (!rstn)
    s_stat_rd ##[1:20] s_data_rd
    |=> (stat_q & snap_q & `ASF_RX_CLR_MASK) == 8'h00)
    else $error("rx flags not cleared by sequence");

  a_idle_block: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && idle_detect && !idle_ok_q && !stat_q[`ASF_IDLE]
    |=> !stat_q[`ASF_IDLE])
    else $error("idle set again without new word");

  a_overrun_keep: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && word_ovr && !stat_q[`ASF_FRAMING]
    |=> stat_q[`ASF_OVERRUN] && $stable(rx_hold_q)
        && !stat_q[`ASF_FRAMING])
    else $error("overrun handling wrong");

  a_late_flag_kept: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && arm_q && data_rd && !snap_q[`ASF_OVERRUN]
    && stat_q[`ASF_OVERRUN] |=> stat_q[`ASF_OVERRUN])
    else $error("late flag cleared");

  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rstn)
    ce && req && avs_waitrequest ##1 ce && req |-> !avs_waitrequest)
    else $error("answer not one cycle after request");
endmodule
`default_nettype wire

// ---- sim/asf_peer_model.sv ----
// remote serial node driving the tx and rx engine strobes
`timescale 1ns/100ps
`default_nettype none
module asf_peer_model
(
  input wire logic core_clk, // clock
  output logic tx_load, // holding moved to shifter
  output logic tx_frame_done, // frame finished
  output logic tx_frame_is_data, // frame carried data
  output logic rx_frame_start, // frame begins
  output logic rx_bit_stb, // samples ready
  output logic [2:0] rx_mid_samples, // samples 8, 9, 10
  output logic rx_word_stb, // word complete
  output logic [8:0] rx_word, // word with parity
  output logic rx_frame_fault, // framing fault
  output logic idle_detect // idle line
);
  initial
  begin
    {tx_load, tx_frame_done, tx_frame_is_data, rx_word_stb} = '0;
    {rx_frame_start, rx_bit_stb, rx_frame_fault, idle_detect} = '0;
    rx_mid_samples = '0;
    rx_word = '0;
  end
  task automatic tx_ev(input logic ld, input logic dn, input logic dat);
    @(posedge core_clk);
    tx_load <= ld;
    tx_frame_done <= dn;
    tx_frame_is_data <= dat;
    @(posedge core_clk);
    tx_load <= 1'b0;
    tx_frame_done <= 1'b0;
    tx_frame_is_data <= ~dat;
  endtask
  task automatic send(input logic [8:0] w, input logic flt,
                      input logic [2:0] s);
    @(posedge core_clk);
    rx_frame_start <= 1'b1;
    @(posedge core_clk);
    rx_frame_start <= 1'b0;
    rx_bit_stb <= 1'b1;
    rx_mid_samples <= s;
    @(posedge core_clk);
    rx_bit_stb <= 1'b0;
    rx_mid_samples <= ~s;
    rx_word_stb <= 1'b1;
    rx_word <= w;
    rx_frame_fault <= flt;
    @(posedge core_clk);
    rx_word_stb <= 1'b0;
    rx_word <= ~w;
    rx_frame_fault <= ~flt;
  endtask
  task automatic idle_line;
    @(posedge core_clk);
    idle_detect <= 1'b1;
    @(posedge core_clk);
    idle_detect <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/asf_status_core_tb.sv ----
// self-checking bench of the serial status flag block
`timescale 1ns/100ps
`default_nettype none
module asf_status_core_tb;
  logic core_clk, rstn, ce, avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic tx_load, tx_frame_done, tx_frame_is_data, tx_hold_full, rx_bit_val;
  logic rx_frame_start, rx_bit_stb, rx_word_stb, rx_frame_fault, idle_detect;
  logic [2:0] rx_mid_samples;
  logic [8:0] rx_word;
  logic [7:0] tx_hold_q, ctrl_q, q;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  asf_status_core uut (.core_clk(core_clk), .rstn(rstn), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_load(tx_load), .tx_frame_done(tx_frame_done),
    .tx_frame_is_data(tx_frame_is_data), .tx_hold_q(tx_hold_q),
    .tx_hold_full(tx_hold_full), .rx_frame_start(rx_frame_start),
    .rx_bit_stb(rx_bit_stb), .rx_mid_samples(rx_mid_samples),
    .rx_bit_val(rx_bit_val), .rx_word_stb(rx_word_stb), .rx_word(rx_word),
    .rx_frame_fault(rx_frame_fault), .idle_detect(idle_detect),
    .ctrl_q(ctrl_q), .irq(irq));
  asf_peer_model peer (.core_clk(core_clk), .tx_load(tx_load),
    .tx_frame_done(tx_frame_done), .tx_frame_is_data(tx_frame_is_data),
    .rx_frame_start(rx_frame_start), .rx_bit_stb(rx_bit_stb),
    .rx_mid_samples(rx_mid_samples), .rx_word_stb(rx_word_stb),
    .rx_word(rx_word), .rx_frame_fault(rx_frame_fault),
    .idle_detect(idle_detect));
  // ==================================================================
  // clock, timeout and closing report
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      conclude;
    end
  end
  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==================================================================
  // bus cycle and comparison helpers
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp,
                     input string nm);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h00_0000, d};
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, 4'h0, 8'h00);
    chk(q & m, e, "status");
  endtask
  task automatic clr_rx;
    bus(1'b0, 4'h0, 8'h00);
    bus(1'b0, 4'h4, 8'h00);
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset;
    st(8'hff, 8'hc0);
    chk(irq, 1'b0, "irq");
    bus(1'b1, 4'h0, 8'h00);
    st(8'hff, 8'hc0);
    bus(1'b0, 4'hc, 8'h00);
    chk(q, 8'h00, "unmapped");
  endtask
  task automatic t_tx;
    bus(1'b1, 4'h8, 8'h80);
    chk(irq, 1'b1, "irq");
    bus(1'b0, 4'h0, 8'h00);
    bus(1'b1, 4'h4, 8'h5a);
    st(8'hff, 8'h00);
    chk(irq, 1'b0, "irq");
    chk({tx_hold_full, tx_hold_q}, 9'h15a, "hold");
    peer.tx_ev(1'b1, 1'b0, 1'b0);
    st(8'hff, 8'h80);
    bus(1'b0, 4'h4, 8'h00);
    bus(1'b1, 4'h4, 8'h00);
    st(8'hff, 8'h80);
    bus(1'b1, 4'h4, 8'h00);
    peer.tx_ev(1'b0, 1'b1, 1'b0);
    st(8'hff, 8'h00);
    peer.tx_ev(1'b0, 1'b1, 1'b1);
    st(8'hff, 8'h40);
    bus(1'b1, 4'h8, 8'h40);
    chk(irq, 1'b1, "irq");
    bus(1'b1, 4'h8, 8'h00);
  endtask
  task automatic t_rx;
    peer.send(9'h055, 1'b0, 3'b011);
    chk(rx_bit_val, 1'b1, "bit");
    st(8'h3f, 8'h24);
    chk(irq, 1'b0, "irq");
    bus(1'b1, 4'h8, 8'h20);
    chk(ctrl_q, 8'h20, "ctrl");
    chk(irq, 1'b1, "irq");
    clr_rx;
    chk(q, 8'h55, "data");
    st(8'h3f, 8'h00);
    peer.send(9'h0a1, 1'b0, 3'b010);
    chk(rx_bit_val, 1'b0, "bit");
    peer.send(9'h0b2, 1'b1, 3'b111);
    st(8'h3f, 8'h2c);
    clr_rx;
    chk(q, 8'ha1, "data");
    peer.send(9'h0c3, 1'b1, 3'b000);
    st(8'h3f, 8'h22);
    clr_rx;
  endtask
  task automatic t_idle;
    bus(1'b1, 4'h8, 8'h10);
    peer.idle_line;
    st(8'h3f, 8'h10);
    chk(irq, 1'b1, "irq");
    clr_rx;
    peer.idle_line;
    st(8'h3f, 8'h00);
    peer.send(9'h011, 1'b0, 3'b000);
    peer.idle_line;
    st(8'h3f, 8'h30);
    clr_rx;
  endtask
  task automatic t_parity;
    bus(1'b1, 4'h8, 8'h05);
    peer.send(9'h001, 1'b0, 3'b000);
    st(8'h3f, 8'h21);
    chk(irq, 1'b1, "irq");
    clr_rx;
    st(8'h3f, 8'h00);
    bus(1'b1, 4'h8, 8'h07);
    peer.send(9'h001, 1'b0, 3'b000);
    st(8'h3f, 8'h20);
    clr_rx;
    bus(1'b1, 4'h8, 8'h0c);
    peer.send(9'h101, 1'b0, 3'b000);
    st(8'h3f, 8'h20);
    clr_rx;
    bus(1'b1, 4'h8, 8'h07);
    bus(1'b0, 4'h0, 8'h00);
    peer.send(9'h003, 1'b0, 3'b000);
    bus(1'b0, 4'h4, 8'h00);
    st(8'h3f, 8'h21);
    clr_rx;
    peer.send(9'h001, 1'b0, 3'b000);
    bus(1'b0, 4'h0, 8'h00);
    peer.send(9'h002, 1'b0, 3'b000);
    bus(1'b0, 4'h4, 8'h00);
    chk(q, 8'h01, "data");
    st(8'h3f, 8'h08);
    clr_rx;
  endtask
  // ==================================================================
  // main sequence
  initial
  begin
    rstn = 1'b0;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_byteenable = 4'h1;
    avs_writedata = '0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_idle;
    t_parity;
    conclude;
  end
endmodule
`default_nettype wire
